// ==== hw/lp_sdram_pkg.sv ====
// Constants, types and decode functions for the low-power SDRAM command pin interface.
package lp_sdram_pkg;

	localparam int DATA_W     = 16;
	localparam int ROW_W      = 13;
	localparam int COL_W      = 9;
	localparam int BANK_W     = 2;
	localparam int BANKS      = 4;
	localparam int MODE_W     = 15;
	localparam int ARRAY_AW   = BANK_W + ROW_W + COL_W;
	localparam int ARRAY_WORDS = 1 << ARRAY_AW;
	localparam int LEN_W      = 10;
	localparam int PIPE_DEPTH = 3;
	localparam int MASK_LATENCY = 2;
	localparam int AUTO_CLOSE_BIT = 10;

	localparam int MODE_BL_LSB  = 0;
	localparam int MODE_BT_BIT  = 3;
	localparam int MODE_CL_LSB  = 4;
	localparam int MODE_OPM_LSB = 7;
	localparam int MODE_WB_BIT  = 9;

	localparam logic [MODE_W-1:0] MODE_RESET = 15'h0020;
	localparam logic [LEN_W-1:0]  FULL_PAGE_LEN = 10'h200;

	typedef enum logic [3:0] {
		CMD_LOAD_MODE = 4'h0,
		CMD_REFRESH   = 4'h1,
		CMD_PRECHARGE = 4'h2,
		CMD_ACTIVATE  = 4'h3,
		CMD_WRITE     = 4'h4,
		CMD_READ      = 4'h5,
		CMD_TERMINATE = 4'h6,
		CMD_NOP       = 4'h7,
		CMD_INHIBIT   = 4'h8
	} cmd_t;

	typedef enum logic [1:0] {
		PWR_NORMAL     = 2'h0,
		PWR_PRECHG_PD  = 2'h1,
		PWR_ACTIVE_PD  = 2'h2,
		PWR_SELF_REF   = 2'h3
	} power_state_t;

	typedef struct packed {
		logic chip_select_n;
		logic row_strobe_n;
		logic col_strobe_n;
		logic write_enable_n;
	} cmd_pins_t;

	typedef struct packed {
		logic high_byte_mask;
		logic low_byte_mask;
	} byte_mask_t;

	// Reserved length codes fall back to a single word.
	function automatic logic [LEN_W-1:0] burst_len_f(input logic [MODE_W-1:0] mode);
		logic [2:0] code;
		code = mode[MODE_BL_LSB +: 3];
		unique case (code)
			3'h0:    burst_len_f = 10'h001;
			3'h1:    burst_len_f = 10'h002;
			3'h2:    burst_len_f = 10'h004;
			3'h3:    burst_len_f = 10'h008;
			3'h7:    burst_len_f = mode[MODE_BT_BIT] ? 10'h001 : FULL_PAGE_LEN;
			default: burst_len_f = 10'h001;
		endcase
	endfunction

	// Reserved latency codes are run as latency two.
	function automatic logic [1:0] cas_tap_f(input logic [MODE_W-1:0] mode);
		logic [2:0] code;
		code = mode[MODE_CL_LSB +: 3];
		unique case (code)
			3'h1:    cas_tap_f = 2'h0;
			3'h3:    cas_tap_f = 2'h2;
			default: cas_tap_f = 2'h1;
		endcase
	endfunction

endpackage

// ==== hw/command_decoder.sv ====
// Turns the sampled strobe levels into one command code.
`timescale 1ns/1ps
module command_decoder
	import lp_sdram_pkg::*;
(
	input  wire lp_sdram_pkg::cmd_pins_t pins_in,
	output lp_sdram_pkg::cmd_t          cmd_out
);
	always_comb begin
		if (pins_in.chip_select_n) begin
			cmd_out = CMD_INHIBIT;
		end else begin
			unique case ({pins_in.row_strobe_n, pins_in.col_strobe_n, pins_in.write_enable_n})
				3'h0: cmd_out = CMD_LOAD_MODE;
				3'h1: cmd_out = CMD_REFRESH;
				3'h2: cmd_out = CMD_PRECHARGE;
				3'h3: cmd_out = CMD_ACTIVATE;
				3'h4: cmd_out = CMD_WRITE;
				3'h5: cmd_out = CMD_READ;
				3'h6: cmd_out = CMD_TERMINATE;
				3'h7: cmd_out = CMD_NOP;
			endcase
		end
	end
endmodule // command_decoder

// ==== hw/burst_column_gen.sv ====
// Column of one burst beat, wrapping within its block in sequential or interleaved order.
`timescale 1ns/1ps
module burst_column_gen
	import lp_sdram_pkg::*;
(
	input  wire logic [COL_W-1:0] start_in,
	input  wire logic [COL_W-1:0] index_in,
	input  wire logic [LEN_W-1:0] length_in,
	input  wire logic             interleave_in,
	output logic      [COL_W-1:0] column_out
);
	logic [LEN_W-1:0] len_less;
	logic [COL_W-1:0] wrap_mask;
	logic [COL_W-1:0] seq_col;

	assign len_less  = length_in - 10'h001;
	assign wrap_mask = len_less[COL_W-1:0];
	assign seq_col   = start_in + index_in;

	always_comb begin
		if (interleave_in) begin
			column_out = (start_in & ~wrap_mask) | ((start_in ^ index_in) & wrap_mask);
		end else begin
			column_out = (start_in & ~wrap_mask) | (seq_col & wrap_mask);
		end
	end
endmodule // burst_column_gen

// ==== hw/lp_sdram_device.sv ====
// Device-side command, bank, burst and data logic of the low-power SDRAM.
`timescale 1ns/1ps
module lp_sdram_device (
	input  wire logic                        clk_in,
	input  wire logic                        rst_in,
	input  wire logic                        cke_in,
	input  wire lp_sdram_pkg::cmd_pins_t     cmd_pins_in,
	input  wire logic                        bank_select_0_in,
	input  wire logic                        bank_select_1_in,
	input  wire logic [12:0]                 address_bus_in,
	input  wire lp_sdram_pkg::byte_mask_t    byte_mask_in,
	input  wire logic [15:0]                 dq_in,
	output logic      [15:0]                 dq_out,
	output logic      [1:0]                  dq_oe_out,
	output lp_sdram_pkg::power_state_t       power_state_out,
	output logic                             clock_suspend_out,
	output logic                             receivers_off_out,
	output logic      [3:0]                  bank_open_out,
	output logic      [14:0]                 mode_reg_out
);
	import lp_sdram_pkg::*;

	logic [DATA_W-1:0]   mem_array [0:ARRAY_WORDS-1];

	power_state_t        power_state_reg;
	power_state_t        power_state_next;
	logic                clock_suspend_reg;
	logic                receivers_off_reg;
	logic [MODE_W-1:0]   mode_reg;
	logic [BANKS-1:0]    bank_open_reg;
	logic [ROW_W-1:0]    bank_row_reg [BANKS];

	logic                burst_active_reg;
	logic                burst_write_reg;
	logic                burst_close_reg;
	logic                burst_il_reg;
	logic [BANK_W-1:0]   burst_bank_reg;
	logic [COL_W-1:0]    burst_start_reg;
	logic [COL_W-1:0]    burst_cnt_reg;
	logic [LEN_W-1:0]    burst_len_reg;

	logic [DATA_W-1:0]   rd_data_reg  [PIPE_DEPTH];
	logic [PIPE_DEPTH-1:0] rd_valid_reg;
	byte_mask_t          mask_pipe_reg [MASK_LATENCY];
	logic [DATA_W-1:0]   dq_out_reg;
	logic [1:0]          dq_oe_reg;

	cmd_t                pin_cmd;
	cmd_t                cmd;
	logic                clk_live;
	logic [BANK_W-1:0]   cmd_bank;
	logic                new_rw;
	logic [LEN_W-1:0]    new_len;
	logic [COL_W-1:0]    gen_start;
	logic [COL_W-1:0]    gen_idx;
	logic [LEN_W-1:0]    gen_len;
	logic                gen_il;
	logic [COL_W-1:0]    access_col;
	logic                access_valid;
	logic                access_write;
	logic                access_close;
	logic [BANK_W-1:0]   access_bank;
	logic [ARRAY_AW-1:0] access_addr;
	logic [LEN_W-1:0]    len_less;
	logic                access_last;
	logic                burst_cut;
	logic [1:0]          cas_tap;

	command_decoder u_decoder (
		.pins_in (cmd_pins_in),
		.cmd_out (pin_cmd)
	);

	assign clk_live = (power_state_reg == PWR_NORMAL) && cke_in;
	assign cmd      = clk_live ? pin_cmd : CMD_INHIBIT;
	assign cmd_bank = {bank_select_1_in, bank_select_0_in};
	assign new_rw   = (cmd == CMD_READ) || (cmd == CMD_WRITE);
	// Single-access write mode forces writes to one beat whatever the programmed length.
	assign new_len  = ((cmd == CMD_WRITE) && mode_reg[MODE_WB_BIT]) ? 10'h001 : burst_len_f(mode_reg);

	assign gen_start = new_rw ? address_bus_in[COL_W-1:0] : burst_start_reg;
	assign gen_idx   = new_rw ? 9'h000 : burst_cnt_reg;
	assign gen_len   = new_rw ? new_len : burst_len_reg;
	// A single-beat burst ignores the type bit; the mask is zero so order cannot matter.
	assign gen_il    = new_rw ? mode_reg[MODE_BT_BIT] : burst_il_reg;

	burst_column_gen u_column (
		.start_in      (gen_start),
		.index_in      (gen_idx),
		.length_in     (gen_len),
		.interleave_in (gen_il),
		.column_out    (access_col)
	);

	// A precharge to the bursting bank, or a terminate, ends the burst without a beat.
	assign burst_cut = (cmd == CMD_TERMINATE) ||
		((cmd == CMD_PRECHARGE) &&
		 (address_bus_in[AUTO_CLOSE_BIT] || (cmd_bank == burst_bank_reg)));
	assign access_valid = new_rw || (clk_live && burst_active_reg && !burst_cut);
	assign access_write = new_rw ? (cmd == CMD_WRITE) : burst_write_reg;
	assign access_close = new_rw ? address_bus_in[AUTO_CLOSE_BIT] : burst_close_reg;
	assign access_bank  = new_rw ? cmd_bank : burst_bank_reg;
	assign access_addr  = {access_bank, bank_row_reg[access_bank], access_col};
	assign len_less     = gen_len - 10'h001;
	// Full-page bursts never end on their own; they wrap until cut.
	assign access_last  = (gen_len != FULL_PAGE_LEN) && (gen_idx == len_less[COL_W-1:0]);
	assign cas_tap      = cas_tap_f(mode_reg);

	always_comb begin
		power_state_next = power_state_reg;
		if (power_state_reg != PWR_NORMAL) begin
			if (cke_in) begin
				power_state_next = PWR_NORMAL;
			end
		end else if (!cke_in && !burst_active_reg) begin
			if (pin_cmd == CMD_REFRESH) begin
				power_state_next = PWR_SELF_REF;
			end else if (|bank_open_reg) begin
				power_state_next = PWR_ACTIVE_PD;
			end else begin
				power_state_next = PWR_PRECHG_PD;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			power_state_reg   <= PWR_NORMAL;
			clock_suspend_reg <= 1'b0;
			receivers_off_reg <= 1'b0;
		end else begin
			power_state_reg   <= power_state_next;
			clock_suspend_reg <= (power_state_reg == PWR_NORMAL) && !cke_in && burst_active_reg;
			receivers_off_reg <= (power_state_next != PWR_NORMAL);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_reg <= MODE_RESET;
		end else if (cmd == CMD_LOAD_MODE) begin
			mode_reg <= {bank_select_1_in, bank_select_0_in, address_bus_in};
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			bank_open_reg <= '0;
			for (int b = 0; b < BANKS; b++) begin
				bank_row_reg[b] <= '0;
			end
		end else begin
			if (access_valid && access_last && access_close) begin
				bank_open_reg[access_bank] <= 1'b0;
			end
			if (cmd == CMD_ACTIVATE) begin
				bank_open_reg[cmd_bank] <= 1'b1;
				bank_row_reg[cmd_bank]  <= address_bus_in;
			end else if (cmd == CMD_PRECHARGE) begin
				if (address_bus_in[AUTO_CLOSE_BIT]) begin
					bank_open_reg <= '0;
				end else begin
					bank_open_reg[cmd_bank] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			burst_active_reg <= 1'b0;
			burst_write_reg  <= 1'b0;
			burst_close_reg  <= 1'b0;
			burst_il_reg     <= 1'b0;
			burst_bank_reg   <= '0;
			burst_start_reg  <= '0;
			burst_cnt_reg    <= '0;
			burst_len_reg    <= 10'h001;
		end else if (new_rw) begin
			burst_active_reg <= !access_last;
			burst_write_reg  <= (cmd == CMD_WRITE);
			burst_close_reg  <= address_bus_in[AUTO_CLOSE_BIT];
			burst_il_reg     <= mode_reg[MODE_BT_BIT];
			burst_bank_reg   <= cmd_bank;
			burst_start_reg  <= address_bus_in[COL_W-1:0];
			burst_cnt_reg    <= 9'h001;
			burst_len_reg    <= new_len;
		end else if (clk_live && burst_active_reg) begin
			if (burst_cut || access_last) begin
				burst_active_reg <= 1'b0;
			end
			burst_cnt_reg <= burst_cnt_reg + 9'h001;
		end
	end

	// The array is not reset; stored data survives a controller reset as in the real part.
	// write data on rising edge
	always_ff @(posedge clk_in) begin
		if (access_valid && access_write) begin
			if (!byte_mask_in.low_byte_mask) begin
				mem_array[access_addr][7:0] <= dq_in[7:0];
			end
			if (!byte_mask_in.high_byte_mask) begin
				mem_array[access_addr][15:8] <= dq_in[15:8];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (clk_live) begin
			rd_data_reg[0] <= mem_array[access_addr];
			for (int s = 1; s < PIPE_DEPTH; s++) begin
				rd_data_reg[s] <= rd_data_reg[s-1];
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_valid_reg <= '0;
			for (int m = 0; m < MASK_LATENCY; m++) begin
				mask_pipe_reg[m] <= '0;
			end
		end else if (clk_live) begin
			rd_valid_reg <= {rd_valid_reg[PIPE_DEPTH-2:0], access_valid && !access_write};
			mask_pipe_reg[0] <= byte_mask_in;
			for (int m = 1; m < MASK_LATENCY; m++) begin
				mask_pipe_reg[m] <= mask_pipe_reg[m-1];
			end
		end
	end

	// Suspended edges hold the driven word, so the controller sees it stretched.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dq_out_reg <= '0;
			dq_oe_reg  <= '0;
		end else if (clk_live) begin
			dq_out_reg <= rd_data_reg[cas_tap];
			dq_oe_reg[0] <= rd_valid_reg[cas_tap] &&
				!mask_pipe_reg[MASK_LATENCY-1].low_byte_mask;
			dq_oe_reg[1] <= rd_valid_reg[cas_tap] &&
				!mask_pipe_reg[MASK_LATENCY-1].high_byte_mask;
		end else if (power_state_reg != PWR_NORMAL) begin
			dq_oe_reg <= '0;
		end
	end

	assign dq_out            = dq_out_reg;
	assign dq_oe_out         = dq_oe_reg;
	assign power_state_out   = power_state_reg;
	assign clock_suspend_out = clock_suspend_reg;
	assign receivers_off_out = receivers_off_reg;
	assign bank_open_out     = bank_open_reg;
	assign mode_reg_out      = mode_reg;

endmodule // lp_sdram_device

// ==== testbench/lp_sdram_props.sv ====
// Concurrent checks on the memory's command, mask and power pins.
`timescale 1ns/1ps
module lp_sdram_props
	import lp_sdram_pkg::*;
(
	input wire logic                       clk_in,
	input wire logic                       rst_in,
	input wire logic                       cke_in,
	input wire lp_sdram_pkg::cmd_pins_t    cmd_pins_in,
	input wire logic                       bank_select_0_in,
	input wire logic                       bank_select_1_in,
	input wire logic [12:0]                address_bus_in,
	input wire lp_sdram_pkg::byte_mask_t   byte_mask_in,
	input wire logic [1:0]                 dq_oe_out,
	input wire lp_sdram_pkg::power_state_t power_state_out,
	input wire logic                       clock_suspend_out,
	input wire logic                       receivers_off_out,
	input wire logic [3:0]                 bank_open_out,
	input wire logic [14:0]                mode_reg_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	logic       taken;
	logic [1:0] bank;
	logic [2:0] code;
	assign taken = cke_in && power_state_out == PWR_NORMAL && !cmd_pins_in.chip_select_n;
	assign bank  = {bank_select_1_in, bank_select_0_in};
	assign code  = {cmd_pins_in.row_strobe_n, cmd_pins_in.col_strobe_n,
		cmd_pins_in.write_enable_n};
	cs_mask_a: assert property (cmd_pins_in.chip_select_n |=> $stable(mode_reg_out))
		else $error("mode register changed while deselected");
	mode_load_a: assert property (taken && code == 3'h0 |=>
		mode_reg_out == $past({bank_select_1_in, bank_select_0_in, address_bus_in}))
		else $error("mode register not loaded from pins");
	bank_open_a: assert property (taken && code == 3'h3 |=> bank_open_out[$past(bank)])
		else $error("activated bank not open");
	close_all_a: assert property (taken && code == 3'h2 && address_bus_in[AUTO_CLOSE_BIT] |=>
		bank_open_out == 4'h0)
		else $error("precharge all left a bank open");
	close_one_a: assert property (taken && code == 3'h2 && !address_bus_in[AUTO_CLOSE_BIT] |=>
		!bank_open_out[$past(bank)])
		else $error("precharged bank still open");
	high_mask_a: assert property (byte_mask_in.high_byte_mask |-> ##3 !dq_oe_out[1])
		else $error("upper lane driven after mask");
	low_mask_a: assert property ($rose(byte_mask_in.low_byte_mask) |-> ##3 dq_oe_out[0] == 1'b0)
		else $error("lower lane driven after mask");
	rx_off_a: assert property (receivers_off_out == (power_state_out != PWR_NORMAL))
		else $error("receiver state disagrees with power state");
	pd_quiet_a: assert property (power_state_out inside {PWR_PRECHG_PD, PWR_ACTIVE_PD} |->
		dq_oe_out == 2'h0)
		else $error("data driven in power-down");
	pd_exit_a: assert property (power_state_out != PWR_NORMAL && cke_in |=>
		power_state_out == PWR_NORMAL)
		else $error("no exit on clock enable");
	suspend_a: assert property (clock_suspend_out |-> !$past(cke_in))
		else $error("suspend without clock enable low");
	cover property (taken && code == 3'h0);
	cover property (dq_oe_out == 2'h1);
	cover property (power_state_out == PWR_SELF_REF);
endmodule // lp_sdram_props

bind lp_sdram_device lp_sdram_props props (.clk_in(clk_in), .rst_in(rst_in), .cke_in(cke_in),
	.cmd_pins_in(cmd_pins_in), .bank_select_0_in(bank_select_0_in),
	.bank_select_1_in(bank_select_1_in), .address_bus_in(address_bus_in),
	.byte_mask_in(byte_mask_in), .dq_oe_out(dq_oe_out), .power_state_out(power_state_out),
	.clock_suspend_out(clock_suspend_out), .receivers_off_out(receivers_off_out),
	.bank_open_out(bank_open_out), .mode_reg_out(mode_reg_out));

// ==== testbench/sdram_ctrl_model.sv ====
// Controller-side model driving the memory's command, address, mask and data pins.
`timescale 1ns/1ps
module sdram_ctrl_model
	import lp_sdram_pkg::*;
#(
	parameter int INIT_CYCLES = 50000
)
(
	input  wire logic               clk_in,
	output logic                    cke_out,
	output lp_sdram_pkg::cmd_pins_t pins_out,
	output logic                    bank_select_0_out,
	output logic                    bank_select_1_out,
	output logic [12:0]             address_out,
	output lp_sdram_pkg::byte_mask_t mask_out,
	output logic [15:0]             dq_out
);
	initial begin
		cke_out = 1'b1;
		pins_out = 4'hf;
		{bank_select_1_out, bank_select_0_out} = 2'h0;
		address_out = 13'h0000;
		mask_out = 2'h0;
		dq_out = 16'h5a5a;
	end
	task automatic issue(input cmd_t c, input logic [1:0] ba, input logic [12:0] a,
			input logic [1:0] m, input logic [15:0] d, input logic ck);
		@(posedge clk_in);
		cke_out <= ck;
		pins_out <= {c == CMD_INHIBIT, c[2:0]};
		{bank_select_1_out, bank_select_0_out} <= ba;
		address_out <= a;
		mask_out <= m;
		dq_out <= d;
	endtask
	// Idle data lines toggle so a stale word can never pass for written data.
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk_in);
			cke_out <= 1'b1;
			pins_out <= 4'h7;
			mask_out <= 2'h0;
			dq_out <= ~dq_out;
		end
	endtask
	// Rows are closed before each refresh; the bench calls this only once, after the power tests.
	task automatic refresh_rows();
		issue(CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0, dq_out, 1'b1);
		issue(CMD_REFRESH, 2'h0, 13'h0000, 2'h0, dq_out, 1'b1);
	endtask
	// Wait, close all, refresh twice, load mode idle.
	task automatic init_seq(input logic [14:0] mode);
		idle(INIT_CYCLES);
		issue(CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0, dq_out, 1'b1);
		issue(CMD_REFRESH, 2'h0, 13'h0000, 2'h0, dq_out, 1'b1);
		idle(2);
		issue(CMD_REFRESH, 2'h0, 13'h0000, 2'h0, dq_out, 1'b1);
		idle(2);
		issue(CMD_LOAD_MODE, mode[14:13], mode[12:0], 2'h0, dq_out, 1'b1);
		idle(2);
	endtask
endmodule // sdram_ctrl_model

// ==== testbench/lp_sdram_command_pin_interface_bench.sv ====
// Self-checking bench for the memory command pin interface.
`timescale 1ns/1ps
module lp_sdram_command_pin_interface_bench;
	import lp_sdram_pkg::*;
	logic         clk_in = 1'b0;
	logic         rst_in = 1'b1;
	logic         cke;
	cmd_pins_t    pins;
	logic         ba0;
	logic         ba1;
	logic [12:0]  addr;
	byte_mask_t   mask;
	logic [15:0]  dq_w;
	logic [15:0]  dq_r;
	logic [1:0]   oe;
	power_state_t pwr;
	logic         susp;
	logic         rx_off;
	logic [3:0]   bank_open;
	logic [14:0]  mode_val;
	int           fails = 0;
	int           tests_run = 0;

	always #2 clk_in = ~clk_in;

	sdram_ctrl_model ctrl (.clk_in(clk_in), .cke_out(cke), .pins_out(pins),
		.bank_select_0_out(ba0), .bank_select_1_out(ba1), .address_out(addr),
		.mask_out(mask), .dq_out(dq_w));
	lp_sdram_device DUT (.clk_in(clk_in), .rst_in(rst_in), .cke_in(cke), .cmd_pins_in(pins),
		.bank_select_0_in(ba0), .bank_select_1_in(ba1), .address_bus_in(addr),
		.byte_mask_in(mask), .dq_in(dq_w), .dq_out(dq_r), .dq_oe_out(oe),
		.power_state_out(pwr), .clock_suspend_out(susp), .receivers_off_out(rx_off),
		.bank_open_out(bank_open), .mode_reg_out(mode_val));

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic done(input string name);
		$display("test %s done, mismatches so far %0d", name, fails);
	endtask
	// Lets the edge's register updates land before looking.
	task automatic wait_look(input int n);
		ctrl.idle(n);
		#1;
	endtask
	task automatic rd(input logic [8:0] col, input logic [1:0] m, input logic [15:0] e0,
			input logic [15:0] e1, input logic [1:0] eo);
		ctrl.issue(CMD_READ, 2'h1, {4'h0, col}, m, dq_w, 1'b1);
		wait_look(3);
		cmp(oe, eo);
		cmp(dq_r & {{8{eo[1]}}, {8{eo[0]}}}, e0);
		wait_look(1);
		cmp(oe, 2'h3);
		cmp(dq_r, e1);
		wait_look(1);
		cmp(oe, 2'h0);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#300000;
		fails++;
		report_and_stop();
	end

	initial begin
		repeat (12) @(posedge clk_in);
		cmp(mode_val, 16'h0020);
		cmp(bank_open, 16'h0000);
		rst_in <= 1'b0;
		done("reset");
		ctrl.init_seq(15'h0021);
		wait_look(0);
		cmp(mode_val, 16'h0021);
		ctrl.issue(CMD_INHIBIT, 2'h3, 13'h1fff, 2'h0, dq_w, 1'b1);
		wait_look(1);
		cmp(mode_val, 16'h0021);
		done("init");
		ctrl.issue(CMD_ACTIVATE, 2'h1, 13'h1234, 2'h0, dq_w, 1'b1);
		ctrl.issue(CMD_ACTIVATE, 2'h2, 13'h0abc, 2'h0, dq_w, 1'b1);
		wait_look(1);
		cmp(bank_open, 16'h0006);
		ctrl.issue(CMD_WRITE, 2'h1, 13'h0004, 2'h0, 16'ha1a1, 1'b1);
		ctrl.issue(CMD_NOP, 2'h1, 13'h0000, 2'h0, 16'hb2b2, 1'b1);
		ctrl.issue(CMD_WRITE, 2'h1, 13'h0005, 2'h0, 16'hc3c3, 1'b1);
		ctrl.issue(CMD_NOP, 2'h1, 13'h0000, 2'h1, 16'hd4d4, 1'b1);
		rd(9'h004, 2'h0, 16'hd4a1, 16'hc3c3, 2'h3);
		rd(9'h005, 2'h2, 16'h00c3, 16'hd4a1, 2'h1);
		ctrl.issue(CMD_READ, 2'h1, 13'h0404, 2'h0, dq_w, 1'b1);
		wait_look(2);
		cmp(bank_open, 16'h0004);
		ctrl.issue(CMD_ACTIVATE, 2'h1, 13'h1234, 2'h0, dq_w, 1'b1);
		wait_look(1);
		cmp(bank_open, 16'h0006);
		done("burst");
		ctrl.issue(CMD_READ, 2'h1, 13'h0004, 2'h0, dq_w, 1'b1);
		ctrl.issue(CMD_NOP, 2'h1, 13'h0000, 2'h0, dq_w, 1'b0);
		wait_look(1);
		cmp(susp, 16'h0001);
		cmp(pwr, PWR_NORMAL);
		wait_look(6);
		cmp(oe, 2'h0);
		done("suspend");
		ctrl.issue(CMD_PRECHARGE, 2'h2, 13'h0000, 2'h0, dq_w, 1'b1);
		wait_look(1);
		cmp(bank_open, 16'h0002);
		ctrl.issue(CMD_NOP, 2'h0, 13'h0000, 2'h0, dq_w, 1'b0);
		wait_look(1);
		cmp(pwr, PWR_ACTIVE_PD);
		cmp(rx_off, 16'h0001);
		wait_look(1);
		cmp(pwr, PWR_NORMAL);
		ctrl.issue(CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0, dq_w, 1'b1);
		wait_look(1);
		cmp(bank_open, 16'h0000);
		ctrl.issue(CMD_NOP, 2'h0, 13'h0000, 2'h0, dq_w, 1'b0);
		wait_look(1);
		cmp(pwr, PWR_PRECHG_PD);
		wait_look(1);
		ctrl.issue(CMD_REFRESH, 2'h0, 13'h0000, 2'h0, dq_w, 1'b0);
		wait_look(1);
		cmp(pwr, PWR_SELF_REF);
		cmp(rx_off, 16'h0001);
		wait_look(1);
		cmp(pwr, PWR_NORMAL);
		done("power");
		ctrl.refresh_rows();
		wait_look(1);
		cmp(bank_open, 16'h0000);
		done("refresh");
		report_and_stop();
	end
endmodule // lp_sdram_command_pin_interface_bench
